/* hw/hsfs_sequencer.sv */
// hot swap start-up, retry and fault sequencer
// assumes analog indications arrive asynchronously on plain pins
`timescale 1ns/1ps
`include "hsfs_defines.svh"

// Notes on behaviour
// - uv and ov filtered for 1 ms
// - pass transistor only while supply in range
// - range checked during delay and always after
// - undervoltage: off, no power good, new delay
// - one 200 ms timer for start and retry
// - power good needs enhancement and normal state
// - power good asserted after 20 ms wait
// - shut-off over 1 ms drops power good
// - over-temperature over 12 us drops power good
// - uv or ov over 1 ms drops power good
// - overcurrent over 3 ms drops power good
// - two power good outputs, opposite polarity
// - start only once shut-off is inactive
// - shut-off clears retries, turns everything off
// - shut-off request filtered for 1 ms
// - release of shut-off restarts sequencing
// - after ov wait for 200 ms in range
// - after overheat wait until die cooled
// - overcurrent cleared inside window is forgiven
// - entering normal operation clears retry counter
module hsfs_sequencer
  import hsfs_pkg::*;
#(
  parameter int CNT_W = `HSFS_CNT_W,
  parameter logic [CNT_W-1:0] N_FILT = CNT_W'(`HSFS_N_FILT),
  parameter logic [CNT_W-1:0] N_THERM = CNT_W'(`HSFS_N_THERM),
  parameter logic [CNT_W-1:0] N_OC = CNT_W'(`HSFS_N_OC),
  parameter logic [CNT_W-1:0] N_DELAY = CNT_W'(`HSFS_N_DELAY),
  parameter logic [CNT_W-1:0] N_PGOOD = CNT_W'(`HSFS_N_PGOOD)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic undervolt_in,
  input wire logic overvolt_in,
  input wire logic overtemp_in,
  input wire logic overcurrent_in,
  input wire logic shutoff_in,
  input wire logic enhanced_in,
  output logic pass_enable,
  output logic power_ok_out_high,
  output logic power_ok_out_n,
  output logic [`HSFS_RETRY_W-1:0] retry_count
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [5:0] meta_reg, meta_next, sync_reg, sync_next;

  always_comb begin
    meta_next = {enhanced_in, undervolt_in, overvolt_in, overtemp_in,
                 overcurrent_in, shutoff_in};
    sync_next = meta_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // shut-off reads active until its pin has been seen
      meta_reg <= 6'h01;
      sync_reg <= 6'h01;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  // ------------------------------------------------------------
  // persistence filters
  // ------------------------------------------------------------
  hsfs_ind_s flt;
  logic enh;
  logic uv_sync, ov_sync, therm_sync, oc_sync, dis_sync;

  // ------------------------------------------------------------
  // indication names
  // ------------------------------------------------------------
  assign enh = sync_reg[5];
  assign uv_sync = sync_reg[4];
  assign ov_sync = sync_reg[3];
  assign therm_sync = sync_reg[2];
  assign oc_sync = sync_reg[1];
  assign dis_sync = sync_reg[0];

  hsfs_filter #(.CNT_W(CNT_W), .LEN(N_FILT)) u_uv (
    .clk(clk),
    .reset(reset),
    .raw(uv_sync),
    .filt(flt.uv)
  );

  hsfs_filter #(.CNT_W(CNT_W), .LEN(N_FILT)) u_ov (
    .clk(clk),
    .reset(reset),
    .raw(ov_sync),
    .filt(flt.ov)
  );

  hsfs_filter #(.CNT_W(CNT_W), .LEN(N_THERM)) u_th (
    .clk(clk),
    .reset(reset),
    .raw(therm_sync),
    .filt(flt.therm)
  );

  hsfs_filter #(.CNT_W(CNT_W), .LEN(N_FILT)) u_dis (
    .clk(clk),
    .reset(reset),
    .raw(dis_sync),
    .filt(flt.dis)
  );

  // overcurrent is not a symmetric filter: clears at once
  logic [CNT_W-1:0] oc_cnt_reg, oc_cnt_next;
  logic oc_trip;

  always_comb begin
    oc_cnt_next = '0;
    if (oc_sync && oc_cnt_reg < N_OC) begin
      oc_cnt_next = oc_cnt_reg + 1'b1;
      // saturates so a long overload keeps the trip set
    end else if (oc_sync) begin
      oc_cnt_next = oc_cnt_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      oc_cnt_reg <= '0;
    end else begin
      oc_cnt_reg <= oc_cnt_next;
    end
  end

  assign oc_trip = (oc_cnt_reg >= N_OC);
  assign flt.oc = oc_trip;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  hsfs_state_e state_reg, state_next;
  logic [CNT_W-1:0] tmr_reg, tmr_next;
  logic [`HSFS_RETRY_W-1:0] retry_reg, retry_next;
  logic pass_reg, pass_next;
  logic pg_reg, pg_next;
  logic pgn_reg, pgn_next;
  logic in_range, fault;
  logic hold_done, delay_done, pgood_done;

  // ------------------------------------------------------------
  // fault summary and interval ends
  // ------------------------------------------------------------
  assign in_range = !flt.uv && !flt.ov;
  assign fault = !in_range || flt.therm || flt.oc;
  assign hold_done = (tmr_reg >= N_FILT - 1'b1);
  assign delay_done = (tmr_reg >= N_DELAY - 1'b1);
  assign pgood_done = (tmr_reg >= N_PGOOD - 1'b1);

  // ------------------------------------------------------------
  // state sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    case (state_reg)
      ST_HOLD: begin
        // leave only after the raw request also read inactive for a
        // full filter interval, so a request held from power-up never
        // lets a delay start before its filter has caught up
        if (flt.dis || dis_sync) begin
          tmr_next = '0;
        end else if (hold_done) begin
          tmr_next = '0;
          state_next = ST_DELAY;
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
      ST_DELAY: begin
        // shared start-up and retry delay; range watched throughout
        if (!in_range || flt.therm) begin
          tmr_next = '0;
        end else if (delay_done) begin
          tmr_next = '0;
          state_next = ST_RAMP;
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
      ST_RAMP: begin
        // pass device on, waiting for full enhancement
        tmr_next = '0;
        if (fault) begin
          state_next = ST_FAULT;
        end else if (enh) begin
          state_next = ST_PGWAIT;
        end
      end
      ST_PGWAIT: begin
        // losing enhancement sends the device back to wait for it
        if (fault || !enh) begin
          tmr_next = '0;
          state_next = fault ? ST_FAULT : ST_RAMP;
        end else if (pgood_done) begin
          tmr_next = '0;
          state_next = ST_NORMAL;
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
      ST_NORMAL: begin
        // enhancement loss here only drops power good
        if (fault) begin
          state_next = ST_FAULT;
        end
      end
      ST_FAULT: begin
        // one cycle, then a fresh delay that holds while still too hot
        tmr_next = '0;
        state_next = ST_DELAY;
      end
      default: begin
        state_next = ST_HOLD;
        tmr_next = '0;
      end
    endcase
    if (flt.dis) begin
      state_next = ST_HOLD;
      tmr_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_HOLD;
      tmr_reg <= '0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
    end
  end

  // ------------------------------------------------------------
  // retry counter
  // ------------------------------------------------------------
  // wraps at its width; there is no retry limit
  always_comb begin
    retry_next = retry_reg;
    if (flt.dis) begin
      retry_next = '0;
    end else if (state_reg == ST_PGWAIT && state_next == ST_NORMAL) begin
      retry_next = '0;
    end else if (state_reg == ST_FAULT) begin
      retry_next = retry_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      retry_reg <= '0;
    end else begin
      retry_reg <= retry_next;
    end
  end

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  // decoded from the next state so each output lands with its state
  always_comb begin
    case (state_next)
      ST_RAMP, ST_PGWAIT, ST_NORMAL: begin
        pass_next = 1'b1;
      end
      default: begin
        pass_next = 1'b0;
      end
    endcase
    pg_next = (state_next == ST_NORMAL) && enh;
    pgn_next = !pg_next;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pass_reg <= 1'b0;
      pg_reg <= 1'b0;
      pgn_reg <= 1'b1;
    end else begin
      pass_reg <= pass_next;
      pg_reg <= pg_next;
      pgn_reg <= pgn_next;
    end
  end

  // ------------------------------------------------------------
  // ports
  // ------------------------------------------------------------
  assign pass_enable = pass_reg;
  assign power_ok_out_high = pg_reg;
  assign power_ok_out_n = pgn_reg;
  assign retry_count = retry_reg;
endmodule

/* hw/hsfs_defines.svh */
// timing constants for the hot swap fault sequencer
// assumes a 20 MHz core clock; counts derive from nominal times
`ifndef HSFS_DEFINES_SVH
`define HSFS_DEFINES_SVH

`define HSFS_CLK_HZ 20000000
`define HSFS_T_FILT_US 1000
`define HSFS_T_THERM_US 12
`define HSFS_T_OC_US 3000
`define HSFS_T_DELAY_US 200000
`define HSFS_T_PGOOD_US 20000
`define HSFS_CYC(us) ((us) * (`HSFS_CLK_HZ / 1000000))
`define HSFS_N_FILT `HSFS_CYC(`HSFS_T_FILT_US)
`define HSFS_N_THERM `HSFS_CYC(`HSFS_T_THERM_US)
`define HSFS_N_OC `HSFS_CYC(`HSFS_T_OC_US)
`define HSFS_N_DELAY `HSFS_CYC(`HSFS_T_DELAY_US)
`define HSFS_N_PGOOD `HSFS_CYC(`HSFS_T_PGOOD_US)
`define HSFS_CNT_W 24
`define HSFS_RETRY_W 8

`endif

/* hw/hsfs_pkg.sv */
// types for the hot swap fault sequencer
// used by hsfs_filter and hsfs_sequencer
package hsfs_pkg;
  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_DELAY = 3'b001,
    ST_RAMP = 3'b010,
    ST_PGWAIT = 3'b011,
    ST_NORMAL = 3'b100,
    ST_FAULT = 3'b101
  } hsfs_state_e;

  typedef struct packed {
    logic uv;
    logic ov;
    logic therm;
    logic oc;
    logic dis;
  } hsfs_ind_s;
endpackage

/* hw/hsfs_filter.sv */
// persistence filter: output follows the input after it held steady
// assumes a synchronous input on clk
`timescale 1ns/1ps
module hsfs_filter
  import hsfs_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter logic [CNT_W-1:0] LEN = 24'h00_0001
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic raw,
  output logic filt
);
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic filt_reg, filt_next;

  always_comb begin
    cnt_next = cnt_reg;
    filt_next = filt_reg;
    if (raw == filt_reg) begin
      cnt_next = '0;
    end else if (cnt_reg >= LEN - 1'b1) begin
      cnt_next = '0;
      filt_next = raw;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= '0;
      filt_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      filt_reg <= filt_next;
    end
  end

  assign filt = filt_reg;
endmodule

/* bench/hsfs_properties.sv */
// port checker for hsfs_sequencer
// assumes a bind from the bench top and small count parameters
`timescale 1ns/1ps
module hsfs_properties
  import hsfs_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter logic [CNT_W-1:0] N_DELAY = 24'h00_0014,
  parameter logic [CNT_W-1:0] N_PGOOD = 24'h00_000a
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic undervolt_in,
  input wire logic overvolt_in,
  input wire logic overtemp_in,
  input wire logic overcurrent_in,
  input wire logic shutoff_in,
  input wire logic pass_enable,
  input wire logic power_ok_out_high,
  input wire logic power_ok_out_n,
  input wire logic [7:0] retry_count
);
  // ----------------
  // cycle counters
  // ----------------
  logic [CNT_W-1:0] off_reg, off_next, on_reg, on_next;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  always_comb begin
    off_next = pass_enable ? '0 : off_reg + 1'b1;
    on_next = pass_enable ? on_reg + 1'b1 : '0;
  end
  always_ff @(posedge clk) begin
    off_reg <= reset ? '0 : off_next;
    on_reg <= reset ? '0 : on_next;
  end
  // ----------------
  // properties
  // ----------------
  a_pg_polarity: assert property (power_ok_out_n == !power_ok_out_high)
    else $error("power good pair disagrees");
  a_pg_pass: assert property (power_ok_out_high |-> pass_enable)
    else $error("power good without pass device");
  a_uv_off: assert property (undervolt_in [*8] |-> ##2 !pass_enable && !power_ok_out_high)
    else $error("undervoltage left output on");
  a_ov_off: assert property (overvolt_in [*8] |-> ##2 !pass_enable && !power_ok_out_high)
    else $error("overvoltage left output on");
  a_therm_off: assert property (overtemp_in [*6] |-> ##2 !pass_enable)
    else $error("overheat left output on");
  a_oc_trip: assert property (overcurrent_in [*8] ##1 overcurrent_in [*3] |-> ##2 !power_ok_out_high)
    else $error("overcurrent left power good on");
  a_shut_clear: assert property (shutoff_in [*8] |-> ##2 !pass_enable && retry_count == 8'h00)
    else $error("shut-off left output or retries");
  a_delay_min: assert property ($rose(pass_enable) |-> off_reg >= N_DELAY)
    else $error("start-up delay too short");
  a_pgwait_min: assert property ($rose(power_ok_out_high) |-> on_reg >= N_PGOOD && retry_count == 8'h00)
    else $error("power good delay too short");
  a_retry_step: assert property (retry_count != $past(retry_count) |->
    retry_count == 8'($past(retry_count) + 8'h01) || retry_count == 8'h00)
    else $error("retry count jumped");
endmodule

/* bench/hsfs_load_model.sv */
// downstream load: reports full enhancement a few cycles after pass turns on
// assumes the bench clock and pass_enable of the sequencer
`timescale 1ns/1ps
module hsfs_load_model #(
  parameter int RAMP = 3
) (
  input wire logic clk,
  input wire logic pass_enable,
  output logic enhanced_in
);
  int cnt = 0;
  initial enhanced_in = 1'h0;
  // enhancement is lost at once when the pass device turns off
  always @(posedge clk) begin
    cnt <= pass_enable ? cnt + 1 : 0;
    enhanced_in <= #1 pass_enable && cnt >= RAMP;
  end
endmodule

/* bench/hsfs_sequencer_bench.sv */
// bench for hsfs_sequencer: start-up, glitch, fault and shut-off tests
// assumes shortened count parameters and the load model
`timescale 1ns/1ps
module hsfs_sequencer_bench import hsfs_pkg::*;;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic shutoff = 1'h1;
  logic [3:0] flt = 4'h0;
  logic enh, pe, pg, pgn;
  logic [7:0] retry;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  // ----------------
  // design and load
  // ----------------
  hsfs_sequencer #(.N_FILT(24'h00_0004), .N_THERM(24'h00_0002), .N_OC(24'h00_0006),
    .N_DELAY(24'h00_0014), .N_PGOOD(24'h00_000a)) hsfs_sequencer_i (
    .clk(clk), .reset(reset), .undervolt_in(flt[0]), .overvolt_in(flt[1]),
    .overtemp_in(flt[2]), .overcurrent_in(flt[3]), .shutoff_in(shutoff), .enhanced_in(enh),
    .pass_enable(pe), .power_ok_out_high(pg), .power_ok_out_n(pgn), .retry_count(retry));
  hsfs_load_model hsfs_load_model_i (.clk(clk), .pass_enable(pe), .enhanced_in(enh));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      test_done;
    end
  end
  // ----------------
  // tasks
  // ----------------
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wait_pg;
    for (int i = 0; i < 300 && pg !== 1'h1; i++) cyc(1);
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------
  // tests
  // ----------------
  initial begin
    cyc(16);
    reset = 1'h0;
    chk({pe, pg, pgn, retry}, 16'h0100);
    cyc(40);
    chk({pe, pg, pgn}, 16'h0001);
    shutoff = 1'h0;
    cyc(20);
    chk(pe, 16'h0000);
    wait_pg;
    chk({pe, pg, pgn, retry}, 16'h0600);
    $display("test start-up done");
    shutoff = 1'h1;
    cyc(2);
    shutoff = 1'h0;
    flt = 4'h1;
    cyc(2);
    flt = 4'h8;
    cyc(4);
    flt = 4'h0;
    cyc(12);
    chk({pe, pg, retry}, 16'h0300);
    $display("test glitches done");
    for (int k = 0; k < 4; k++) begin
      flt = 4'(1 << k);
      cyc(14);
      chk({pe, pg, retry}, 16'h0001);
      if (k < 3) cyc(26);
      if (k < 3) chk(pe, 16'h0000);
      flt = 4'h0;
      wait_pg;
      chk({pg, retry}, 16'h0100);
      $display("test fault %0d done", k);
    end
    flt = 4'h8;
    cyc(14);
    flt = 4'h0;
    shutoff = 1'h1;
    cyc(12);
    chk({pe, pg, retry}, 16'h0000);
    shutoff = 1'h0;
    wait_pg;
    chk(pg, 16'h0001);
    $display("test shut-off done");
    test_done;
  end
endmodule

bind hsfs_sequencer hsfs_properties #(.CNT_W(CNT_W), .N_DELAY(N_DELAY), .N_PGOOD(N_PGOOD))
  hsfs_properties_i (.clk(clk), .reset(reset), .undervolt_in(undervolt_in),
  .overvolt_in(overvolt_in), .overtemp_in(overtemp_in), .overcurrent_in(overcurrent_in),
  .shutoff_in(shutoff_in), .pass_enable(pass_enable), .power_ok_out_high(power_ok_out_high),
  .power_ok_out_n(power_ok_out_n), .retry_count(retry_count));
